/* design/supply_monitor_params.svh */
`ifndef SUPPLY_MONITOR_PARAMS_SVH
`define SUPPLY_MONITOR_PARAMS_SVH
// Behaviour
// - Interrupt-reset mode: high irq, low reset
// - Reset mode: single threshold sets, releases reset
// - Interrupt mode: hold, then irq both crossings
// - Control bit 0 shows supply below level
// - Monitor reset sets reset-cause bit 0
// - Four pins give one-shot crossing interrupts
// - Control bit 7 gates level-select writes
// - Write enable sets mask, blocks monitor irq and reset set (not interrupt-mode hold)
// - Interrupt-reset mode masks during settling wait
// - Control bits 0 and 1 read-only
// - Other resets clear write enable; monitor reset keeps it
// - Level-select bit 7 picks monitor mode
// - Top select bits code voltage, 111 off
// - Fourteen levels via option and register
// - Threshold field loads from option at reset
// - Option mode bits give mode, level reset
// - Interrupt-reset irq sets mode, level bits

`define ADDR_W            20
`define CTRL_OFFSET       20'hFFFA9
`define LEVEL_OFFSET      20'hFFFAA
`define IRQ_STATUS_OFFSET 20'hFFFAB
`define IRQ_MASK_OFFSET   20'hFFFAC
`define RESET_CAUSE_OFFSET 20'hFFFAD

`define CTRL_BELOW_BIT    0
`define CTRL_MASK_BIT     1
`define CTRL_WEN_BIT      7
`define LEVEL_CHOICE_BIT  0
`define LEVEL_SEL_LSB     1
`define LEVEL_SEL_MSB     5
`define LEVEL_MODE_BIT    7
`define LEVEL_WR_MASK     8'hBF
`define CAUSE_MON_BIT     0

`define OPT_MODE_LSB      0
`define OPT_DETECT_LEVEL_SELECT_LSB      2
`define OPT_VPOC_LSB      5
`define OPT_IRQ_RST       2'h2
`define OPT_RST           2'h3
`define OPT_IRQ           2'h1
`define SEL_OFF           3'h7

`define CTRL_RESET        8'h00
`define STATUS_RESET      5'h00
`define MASK_RESET        5'h00

`define CLK_MHZ           125
`define SETTLE_NS         10000
`define SETTLE_CYCLES     ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)
`endif

/* design/supply_monitor_pkg.sv */
package supply_monitor_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [4:0] event_t;
   typedef enum logic [3:0]
   {
      MODE_OFF     = 4'h1,
      MODE_IRQ_RST = 4'h2,
      MODE_RST     = 4'h4,
      MODE_IRQ     = 4'h8
   } op_mode_e;
endpackage

/* design/level_sync.sv */
`timescale 1ns/10ps
module level_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             clk_en_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] stable_o,
   output logic      [WIDTH-1:0] changed_o
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] stable_d;
   logic [2:0]       warm_q;
   logic             warm;

   // A bit moves only when the last two stages agree
   assign stable_d = (s2_q & s3_q) | (stable_o & (s2_q | s3_q));
   // Stages start from zero, not the pin level: no event until filled,
   // so a high pin gives no false edge after reset
   assign warm     = warm_q == 3'h4;

   always_ff @(posedge clk_i)
   begin
      if (clk_en_i)
      begin
         if (!rst_b_i)
         begin
            s1_q      <= '0;
            s2_q      <= '0;
            s3_q      <= '0;
            stable_o  <= '0;
            changed_o <= '0;
            warm_q    <= 3'h0;
         end
         else
         begin
            s1_q      <= async_i;
            s2_q      <= s1_q;
            s3_q      <= s2_q;
            stable_o  <= stable_d;
            if (!warm)
               warm_q <= warm_q + 3'h1;
            if (warm)
               changed_o <= stable_d ^ stable_o;
            else
               changed_o <= '0;
         end
      end
   end
endmodule

/* design/supply_monitor_control.sv */
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`include "supply_monitor_params.svh"
module supply_monitor_control #(
   parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
   input  wire logic                        clk_i,
   input  wire logic                        rst_b_i,
   input  wire logic                        por_b_i,
   input  wire logic                        clk_en_i,
   input  wire logic [`ADDR_W-1:0]          addr_i,
   input  wire supply_monitor_pkg::byte_t   wdata_i,
   input  wire logic                        wr_i,
   input  wire logic                        rd_i,
   output supply_monitor_pkg::byte_t        rdata_o,
   input  wire supply_monitor_pkg::byte_t   opt_byte_i,
   input  wire logic                        above_high_i,
   input  wire logic                        above_low_i,
   input  wire logic                        main_pin_above_i,
   input  wire logic                        battery_pin_above_i,
   input  wire logic                        clock_supply_above_i,
   input  wire logic                        external_pin_above_i,
   output logic                             monitor_reset_o,
   output logic                             monitor_interrupt_o,
   output logic                             main_pin_event_o,
   output logic                             battery_pin_event_o,
   output logic                             clock_supply_event_o,
   output logic                             external_pin_event_o,
   output logic [4:0]                       threshold_select_o,
   output logic                             level_choice_o,
   output logic                             irq_o
);
   import supply_monitor_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Functions

   function automatic byte_t level_reset(input byte_t opt);
      byte_t v;
      v = 8'h00;
      v[`LEVEL_SEL_MSB:`LEVEL_SEL_LSB] = {opt[`OPT_VPOC_LSB+:3],
                                          opt[`OPT_DETECT_LEVEL_SELECT_LSB+:2]};
      case (opt[`OPT_MODE_LSB+:2])
         `OPT_RST:
         begin
            v[`LEVEL_MODE_BIT]   = 1'b1;
            v[`LEVEL_CHOICE_BIT] = 1'b1;
         end
         `OPT_IRQ:
            v[`LEVEL_CHOICE_BIT] = 1'b1;
         default:
            v[`LEVEL_CHOICE_BIT] = 1'b0;
      endcase
      return v;
   endfunction

   function automatic op_mode_e decode_mode(input byte_t opt,
                                            input byte_t lvl);
      op_mode_e m;
      if (lvl[`LEVEL_SEL_MSB-:3] == `SEL_OFF)
         m = MODE_OFF;
      else if (opt[`OPT_MODE_LSB+:2] == `OPT_IRQ_RST)
         m = MODE_IRQ_RST;
      else if (opt[`OPT_MODE_LSB+:2] == 2'h0)
         m = MODE_OFF;
      else if (lvl[`LEVEL_MODE_BIT])
         m = MODE_RST;
      else
         m = MODE_IRQ;
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Declarations

   logic [5:0]  sync_stable;
   logic [5:0]  sync_changed;
   logic        above_hi;
   logic        above_lo;
   logic [3:0]  pin_changed;
   logic        hi_fell;
   logic        lo_changed;

   byte_t       opt_q;
   byte_t       level_q;
   byte_t       level_d;
   logic        wen_q;
   logic        wen_d;
   logic        mon_rst_q;
   logic        mon_rst_d;
   logic        hold_q;
   logic        rst_seen_q;
   logic        cause_q;
   logic [15:0] settle_q;
   logic [15:0] settle_d;
   logic        irq_evt_q;
   logic [3:0]  pin_evt_q;
   event_t      status_q;
   event_t      status_d;
   event_t      mask_q;
   byte_t       rdata_q;
   byte_t       rdata_d;

   op_mode_e    mode;
   logic        off;
   logic        out_mask;
   logic        settling;
   logic        below;
   logic        at_level;
   logic        mon_irq;
   logic        settle_start;
   logic        ctrl_sel;
   logic        level_sel;
   logic        status_sel;
   logic        mask_sel;
   logic        cause_sel;
   logic        level_wr;
   event_t      new_events;

   ////////////////////////////////////////////////////////////////////
   // Input synchronisers

   level_sync #(
      .WIDTH (6)
   ) u_sync (
      .clk_i     (clk_i),
      .rst_b_i   (por_b_i),
      .clk_en_i  (clk_en_i),
      .async_i   ({external_pin_above_i, clock_supply_above_i,
                   battery_pin_above_i, main_pin_above_i,
                   above_low_i, above_high_i}),
      .stable_o  (sync_stable),
      .changed_o (sync_changed)
   );

   assign above_hi    = sync_stable[0];
   assign above_lo    = sync_stable[1];
   assign pin_changed = sync_changed[5:2];
   assign hi_fell     = sync_changed[0] & ~sync_stable[0];
   assign lo_changed  = sync_changed[1];

   ////////////////////////////////////////////////////////////////////
   // Decode

   assign ctrl_sel   = addr_i == `CTRL_OFFSET;
   assign level_sel  = addr_i == `LEVEL_OFFSET;
   assign status_sel = addr_i == `IRQ_STATUS_OFFSET;
   assign mask_sel   = addr_i == `IRQ_MASK_OFFSET;
   assign cause_sel  = addr_i == `RESET_CAUSE_OFFSET;
   assign level_wr   = wr_i & level_sel & wen_q;

   assign mode     = decode_mode(opt_q, level_q);
   assign off      = mode == MODE_OFF;
   assign settling = settle_q != 16'h0000;
   // Settling only matters where two levels share one comparator
   assign out_mask = wen_q | (mode == MODE_IRQ_RST & settling);

   // Selected detection level follows the level choice bit
   assign at_level = level_q[`LEVEL_CHOICE_BIT] ? above_lo : above_hi;
   assign below    = ~off & ~at_level;

   always_comb
   begin
      mon_irq = 1'b0;
      case (mode)
         MODE_IRQ_RST:
            mon_irq = hi_fell & ~level_q[`LEVEL_CHOICE_BIT];
         MODE_IRQ:
            mon_irq = lo_changed & ~hold_q;
         MODE_RST:
            mon_irq = 1'b0;
         MODE_OFF:
            mon_irq = 1'b0;
         default:
            mon_irq = 1'b0;
      endcase
      mon_irq = mon_irq & ~out_mask & rst_b_i;
   end

   assign settle_start = mode == MODE_IRQ_RST &
                         (mon_irq |
                          (level_wr & (wdata_i[`LEVEL_CHOICE_BIT] !=
                                       level_q[`LEVEL_CHOICE_BIT])));

   ////////////////////////////////////////////////////////////////////
   // Reset generation

   always_comb
   begin
      mon_rst_d = mon_rst_q;
      case (mode)
         MODE_IRQ_RST:
         begin
            if (above_hi)
               mon_rst_d = 1'b0;
            else if (~above_lo & ~out_mask)
               mon_rst_d = 1'b1;
         end
         MODE_RST:
         begin
            if (above_lo)
               mon_rst_d = 1'b0;
            else if (~out_mask)
               mon_rst_d = 1'b1;
         end
         MODE_IRQ:
            mon_rst_d = hold_q;
         MODE_OFF:
            mon_rst_d = 1'b0;
         default:
            mon_rst_d = 1'b0;
      endcase
   end

   // Monitor state survives the chip reset it drives itself
   always_ff @(posedge clk_i)
   begin
      if (clk_en_i)
      begin
         if (!por_b_i)
            mon_rst_q <= 1'b0;
         else
            mon_rst_q <= mon_rst_d;
      end
   end

   // Hold armed at reset release only while supply is low,
   // so a lingering chip reset cannot re-arm it forever
   always_ff @(posedge clk_i)
   begin
      if (clk_en_i)
      begin
         if (!por_b_i)
         begin
            hold_q     <= 1'b1;
            rst_seen_q <= 1'b1;
         end
         else
         begin
            rst_seen_q <= ~rst_b_i;
            if (above_lo)
               hold_q <= 1'b0;
            else if (rst_seen_q & rst_b_i)
               hold_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (clk_en_i)
      begin
         if (!por_b_i)
            cause_q <= 1'b0;
         else if (mon_rst_q)
            cause_q <= 1'b1;
         else if (wr_i & cause_sel & wdata_i[`CAUSE_MON_BIT])
            cause_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Control and level registers

   always_comb
   begin
      wen_d = wen_q;
      if (!rst_b_i)
         wen_d = mon_rst_q & wen_q;
      else if (wr_i & ctrl_sel)
         wen_d = wdata_i[`CTRL_WEN_BIT];
   end

   always_comb
   begin
      level_d = level_q;
      if (!rst_b_i)
         level_d = level_reset(opt_byte_i);
      else if (mon_irq & mode == MODE_IRQ_RST)
      begin
         level_d[`LEVEL_MODE_BIT]   = 1'b1;
         level_d[`LEVEL_CHOICE_BIT] = 1'b1;
      end
      else if (level_wr)
         level_d = wdata_i & `LEVEL_WR_MASK;
   end

   always_comb
   begin
      settle_d = settle_q;
      if (settle_start)
         settle_d = SETTLE_CYCLES[15:0];
      else if (settling)
         settle_d = settle_q - 16'h0001;
   end

   always_ff @(posedge clk_i)
   begin
      if (clk_en_i)
      begin
         if (!por_b_i)
         begin
            wen_q    <= 1'b0;
            level_q  <= level_reset(opt_byte_i);
            opt_q    <= opt_byte_i;
            settle_q <= 16'h0000;
         end
         else
         begin
            wen_q    <= wen_d;
            level_q  <= level_d;
            settle_q <= settle_d;
            if (!rst_b_i)
               opt_q <= opt_byte_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Events and interrupt status

   assign new_events = {pin_changed & {4{rst_b_i}}, mon_irq};

   always_comb
   begin
      status_d = status_q;
      if (wr_i & status_sel)
         status_d = status_q & ~wdata_i[4:0];
      // Set wins over a clear in the same cycle
      status_d = status_d | new_events;
   end

   always_ff @(posedge clk_i)
   begin
      if (clk_en_i)
      begin
         if (!rst_b_i)
         begin
            irq_evt_q <= 1'b0;
            pin_evt_q <= 4'h0;
            status_q  <= `STATUS_RESET;
            mask_q    <= `MASK_RESET;
         end
         else
         begin
            irq_evt_q <= mon_irq;
            pin_evt_q <= new_events[4:1];
            status_q  <= status_d;
            if (wr_i & mask_sel)
               mask_q <= wdata_i[4:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read path

   always_comb
   begin
      rdata_d = 8'h00;
      if (rd_i)
      begin
         if (ctrl_sel)
            rdata_d = {wen_q, 5'h00, out_mask, below};
         else if (level_sel)
            rdata_d = level_q;
         else if (status_sel)
            rdata_d = {3'h0, status_q};
         else if (mask_sel)
            rdata_d = {3'h0, mask_q};
         else if (cause_sel)
            rdata_d = {7'h00, cause_q};
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (clk_en_i)
      begin
         if (!rst_b_i)
            rdata_q <= 8'h00;
         else
            rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs

   assign rdata_o              = rdata_q;
   assign monitor_reset_o      = mon_rst_q;
   assign monitor_interrupt_o  = irq_evt_q;
   assign main_pin_event_o     = pin_evt_q[0];
   assign battery_pin_event_o  = pin_evt_q[1];
   assign clock_supply_event_o = pin_evt_q[2];
   assign external_pin_event_o = pin_evt_q[3];
   // Analogue side builds one of fourteen levels from this field
   assign threshold_select_o   = level_q[`LEVEL_SEL_MSB:`LEVEL_SEL_LSB];
   assign level_choice_o       = level_q[`LEVEL_CHOICE_BIT];
   assign irq_o                = |(status_q & mask_q);
endmodule

/* verification/supply_monitor_control_assertions.sv */
`timescale 1ns/10ps
`include "supply_monitor_params.svh"
module supply_monitor_checker
   import supply_monitor_pkg::*;
#(
   parameter int SETTLE_CYCLES = 8
) (
   input wire logic                      clk_i,
   input wire logic                      rst_b_i,
   input wire logic                      por_b_i,
   input wire logic [`ADDR_W-1:0]        addr_i,
   input wire supply_monitor_pkg::byte_t wdata_i,
   input wire logic                      wr_i,
   input wire logic                      rd_i,
   input wire supply_monitor_pkg::byte_t rdata_o,
   input wire supply_monitor_pkg::byte_t opt_byte_i,
   input wire logic                      above_low_i,
   input wire logic                      main_pin_above_i,
   input wire logic                      external_pin_above_i,
   input wire logic                      monitor_reset_o,
   input wire logic                      monitor_interrupt_o,
   input wire logic                      main_pin_event_o,
   input wire logic                      external_pin_event_o,
   input wire logic [4:0]                threshold_select_o
);
   logic wen_q;
   logic rd_ctrl_q;
   logic rd_lvl_q;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i || !por_b_i);

   // Shadow write enable; a monitor-caused reset leaves it alone
   always_ff @(posedge clk_i)
   begin
      rd_ctrl_q <= rd_i && addr_i == `CTRL_OFFSET;
      rd_lvl_q  <= rd_i && addr_i == `LEVEL_OFFSET;
      if (!por_b_i || (!rst_b_i && !monitor_reset_o))
         wen_q <= 1'b0;
      else if (wr_i && addr_i == `CTRL_OFFSET)
         wen_q <= wdata_i[`CTRL_WEN_BIT];
   end

   ////////////////////////////////////////////////////////////////
   a_ctrl_fixed:
      assert property (rd_ctrl_q |-> rdata_o[6:2] == 5'h00)
      else $error("control bits 6:2 not zero");
   a_mask_shown:
      assert property (rd_ctrl_q && rdata_o[7] |-> rdata_o[1])
      else $error("mask status clear while writes enabled");
   a_level_bit6:
      assert property (rd_lvl_q |-> !rdata_o[6])
      else $error("level bit 6 not zero");
   a_wen_gate:
      assert property (wr_i && addr_i == `LEVEL_OFFSET && !wen_q
         |=> $stable(threshold_select_o))
      else $error("level write taken while disabled");
   a_mask_blocks:
      assert property (wen_q && $past(wen_q) |-> !monitor_interrupt_o)
      else $error("monitor interrupt while masked");
   a_reset_follows:
      assert property (disable iff (!por_b_i)
         (opt_byte_i[1:0] == `OPT_RST && opt_byte_i[7:5] != `SEL_OFF
         && !wen_q && $stable(above_low_i))[*8]
         |-> monitor_reset_o == !above_low_i)
      else $error("monitor reset does not follow supply");
   a_ext_event:
      assert property ($changed(external_pin_above_i)
         |-> ##[2:8] external_pin_event_o)
      else $error("no event after pin crossing");
   a_main_cause:
      assert property (main_pin_event_o
         |-> $past(main_pin_above_i, 2) != $past(main_pin_above_i, 8))
      else $error("pin event without crossing");
   a_event_single:
      assert property (main_pin_event_o |=> !main_pin_event_o)
      else $error("pin event longer than one cycle");

   c_pin_event: cover property (main_pin_event_o);
   c_mon_irq: cover property (monitor_interrupt_o);
   c_mon_reset: cover property ($rose(monitor_reset_o));
endmodule

bind supply_monitor_control supply_monitor_checker #(
   .SETTLE_CYCLES(SETTLE_CYCLES)
) i_checker (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .por_b_i(por_b_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .opt_byte_i(opt_byte_i),
   .above_low_i(above_low_i), .main_pin_above_i(main_pin_above_i),
   .external_pin_above_i(external_pin_above_i),
   .monitor_reset_o(monitor_reset_o),
   .monitor_interrupt_o(monitor_interrupt_o),
   .main_pin_event_o(main_pin_event_o),
   .external_pin_event_o(external_pin_event_o),
   .threshold_select_o(threshold_select_o)
);

/* verification/supply_comparators.sv */
`timescale 1ns/10ps
module supply_comparators #(
   parameter int DELAY_NS = 2
) (
   input  wire logic [1:0] supply_lvl_i,
   input  wire logic [3:0] pin_lvl_i,
   output logic            above_high_o,
   output logic            above_low_o,
   output logic [3:0]      pin_above_o
);
   // Level 2 clears both thresholds, 1 only the low one
   assign #(DELAY_NS) above_high_o = supply_lvl_i >= 2'h2;
   assign #(DELAY_NS) above_low_o  = supply_lvl_i >= 2'h1;
   assign #(DELAY_NS) pin_above_o  = pin_lvl_i;
endmodule

/* verification/supply_monitor_control_tb.sv */
`timescale 1ns/10ps
`include "supply_monitor_params.svh"
module supply_monitor_control_tb;
   import supply_monitor_pkg::*;
`define CHK(g, e) \
   begin \
      comparisons++; \
      if ((g) !== (e)) \
      begin \
         num_errors++; \
         $display("BAD %0t: got %h expected %h", $time, g, e); \
      end \
   end
   logic        clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        por_b_i = 1'b0;
   logic        clk_en_i = 1'b1;
   logic [19:0] addr_i = 20'h00000;
   byte_t       wdata_i = 8'h00;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   byte_t       opt_byte_i = 8'h13;
   logic [1:0]  supply = 2'h2;
   logic [3:0]  pins = 4'h0;
   byte_t       rdata_o, d, v;
   logic        ab_hi, ab_lo, mon_rst, mon_irq, irq_o, choice;
   logic [3:0]  pin_above, ev;
   logic [4:0]  sel;
   logic [31:0] rnd = 32'h8F7677F8;
   int          num_errors = 0, comparisons = 0, n_irq = 0, k;
   int          n_ev [4] = '{default: 0};

   always #4 clk_i = ~clk_i;
   supply_comparators #(.DELAY_NS(6)) i_comp (.supply_lvl_i(supply),
      .pin_lvl_i(pins), .above_high_o(ab_hi), .above_low_o(ab_lo),
      .pin_above_o(pin_above));
   supply_monitor_control #(.SETTLE_CYCLES(8)) i_dut (.clk_i(clk_i),
      .rst_b_i(rst_b_i), .por_b_i(por_b_i), .clk_en_i(clk_en_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .opt_byte_i(opt_byte_i), .above_high_i(ab_hi),
      .above_low_i(ab_lo), .main_pin_above_i(pin_above[0]),
      .battery_pin_above_i(pin_above[1]),
      .clock_supply_above_i(pin_above[2]),
      .external_pin_above_i(pin_above[3]), .monitor_reset_o(mon_rst),
      .monitor_interrupt_o(mon_irq), .main_pin_event_o(ev[0]),
      .battery_pin_event_o(ev[1]), .clock_supply_event_o(ev[2]),
      .external_pin_event_o(ev[3]), .threshold_select_o(sel),
      .level_choice_o(choice), .irq_o(irq_o));

   always @(posedge clk_i)
   begin
      n_irq += int'(mon_irq === 1'b1);
      for (int i = 0; i < 4; i++)
         n_ev[i] += int'(ev[i] === 1'b1);
   end

   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic byte_t lvl_exp(input byte_t o);
      return {o[1] & o[0], 1'b0, o[7:5], o[3:2], o[0]};
   endfunction
   task automatic wr(input logic [19:0] a, input byte_t x);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= x;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [19:0] a, output byte_t x);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 x = rdata_o;
   endtask
   task automatic boot(input byte_t o, input logic por);
      @(posedge clk_i);
      opt_byte_i <= o;
      por_b_i    <= !por;
      rst_b_i    <= 1'b0;
      repeat (4) @(posedge clk_i);
      por_b_i <= 1'b1;
      rst_b_i <= 1'b1;
      repeat (12) @(posedge clk_i);
   endtask
   task automatic test_done;
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      #100000;
      num_errors++;
      test_done();
   end

   initial
   begin
      logic [1:0] modes [3];
      modes = '{2'h2, 2'h1, 2'h3};
      pins = rnd[3:0];
      for (int m = 0; m < 3; m++)
      begin
         rnd = lfsr(rnd);
         v = {1'b0, rnd[1:0], 1'b1, rnd[3:2], modes[m]};
         boot(v, 1'b1);
         rd(`LEVEL_OFFSET, d);
         `CHK(d, lvl_exp(v))
         `CHK(sel, {v[7:5], v[3:2]})
         `CHK(choice, v[0])
      end
      rd(`CTRL_OFFSET, d);
      `CHK(d, 8'h00)
      wr(`CTRL_OFFSET, 8'hFF);
      rd(`CTRL_OFFSET, d);
      `CHK(d, 8'h82)
      rnd = lfsr(rnd);
      v = {4'h8, rnd[3:0]} << 1 | 8'h81;
      wr(`LEVEL_OFFSET, v);
      rd(`LEVEL_OFFSET, d);
      `CHK(d, v)
      wr(`CTRL_OFFSET, 8'h00);
      wr(`LEVEL_OFFSET, v ^ 8'h1E);
      rd(`LEVEL_OFFSET, d);
      `CHK(d, v)
      rd(20'hFFFB0, d);
      `CHK(d, 8'h00)
      wr(`CTRL_OFFSET, 8'h80);
      boot(opt_byte_i, 1'b0);
      rd(`CTRL_OFFSET, d);
      `CHK(d, 8'h00)
      supply <= 2'h0;
      repeat (12) @(posedge clk_i);
      `CHK(mon_rst, 1'b1)
      rd(`CTRL_OFFSET, d);
      `CHK(d, 8'h01)
      rd(`RESET_CAUSE_OFFSET, d);
      `CHK(d[0], 1'b1)
      wr(`CTRL_OFFSET, 8'h80);
      boot(opt_byte_i, 1'b0);
      rd(`CTRL_OFFSET, d);
      `CHK(d[7], 1'b1)
      wr(`CTRL_OFFSET, 8'h00);
      supply <= 2'h2;
      repeat (12) @(posedge clk_i);
      `CHK(mon_rst, 1'b0)
      wr(`IRQ_MASK_OFFSET, 8'h1F);
      for (int i = 0; i < 4; i++)
      begin
         k = n_ev[i];
         pins[i] <= ~pins[i];
         repeat (12) @(posedge clk_i);
         `CHK(n_ev[i], k + 1)
         `CHK(irq_o, 1'b1)
         rd(`IRQ_STATUS_OFFSET, d);
         `CHK(d, 8'h01 << (i + 1))
         wr(`IRQ_STATUS_OFFSET, d);
         `CHK(irq_o, 1'b0)
      end
      wr(`IRQ_MASK_OFFSET, 8'h00);
      pins[0] <= ~pins[0];
      repeat (12) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      boot(8'hF3, 1'b1);
      supply <= 2'h0;
      repeat (12) @(posedge clk_i);
      `CHK(mon_rst, 1'b0)
      rd(`CTRL_OFFSET, d);
      `CHK(d, 8'h00)
      supply <= 2'h2;
      boot(8'h1A, 1'b1);
      wr(`IRQ_MASK_OFFSET, 8'h01);
      supply <= 2'h1;
      for (k = 0; k < 20 && mon_irq !== 1'b1; k++)
         @(posedge clk_i);
      rd(`CTRL_OFFSET, d);
      `CHK(d[1], 1'b1)
      `CHK(irq_o, 1'b1)
      `CHK(mon_rst, 1'b0)
      rd(`LEVEL_OFFSET, d);
      `CHK({d[7], d[0]}, 2'b11)
      repeat (12) @(posedge clk_i);
      rd(`CTRL_OFFSET, d);
      `CHK(d, 8'h00)
      supply <= 2'h0;
      repeat (12) @(posedge clk_i);
      `CHK(mon_rst, 1'b1)
      supply <= 2'h2;
      repeat (12) @(posedge clk_i);
      `CHK(mon_rst, 1'b0)
      supply <= 2'h0;
      boot(8'h11, 1'b1);
      `CHK(mon_rst, 1'b1)
      supply <= 2'h2;
      repeat (12) @(posedge clk_i);
      `CHK(mon_rst, 1'b0)
      k = n_irq;
      supply <= 2'h0;
      repeat (12) @(posedge clk_i);
      supply <= 2'h2;
      repeat (12) @(posedge clk_i);
      `CHK(n_irq, k + 2)
      `CHK(mon_rst, 1'b0)
      test_done();
   end
endmodule
